// ===== design/nff_fifo.sv
// Show-ahead FIFO with valid and ready on both sides
// Assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
module nff_fifo
  import nff_pkg::*;
#(
  parameter int W  = 8,
  parameter int D  = 8,
  parameter int AW = $clog2(D)
) (
  // Clock, reset and flush
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         flush_in,
  // Fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  // Drain side
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in,
  output logic [AW:0]       count_out
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } nff_fifo_type;

  nff_fifo_type f_r;
  nff_fifo_type f_nxt;
  logic         push;
  logic         pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == (AW)'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // Pointers wrap at the depth, which need not be a power of two
  always_comb begin
    f_nxt         = f_r;
    in_ready_out  = f_r.cnt != (AW+1)'(D);
    out_valid_out = f_r.cnt != '0;
    push          = in_valid_in && in_ready_out;
    pop           = out_valid_out && out_ready_in;
    if (push) begin
      f_nxt.wp = ptr_inc(f_r.wp);
    end
    if (pop) begin
      f_nxt.rp = ptr_inc(f_r.rp);
    end
    f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_in) begin
      f_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign count_out = f_r.cnt;

  // Read address looks ahead so the head is ready next cycle
  nff_mem #(.W(W), .D(D), .AW(AW)) u_mem (
    .clk_in (clk_in),
    .we_in  (push),
    .wa_in  (f_r.wp),
    .wd_in  (in_data_in),
    .ra_in  (f_nxt.rp),
    .rd_out (out_data_out)
  );

  a_fifo_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R09]
    f_r.cnt == (AW+1)'(D) |-> !in_ready_out ##1 f_r.cnt <= (AW+1)'(D))
    else $error("fifo count passed its depth");
endmodule

// ===== design/nff_frame_fifo_path.sv
// Framing path: SPI slave, 96-byte FIFO, receive and transmit framers
// Assumes the controller is SPI master; sclk stands still outside frames
`timescale 1ns/1ps
module nff_frame_fifo_path
  import nff_pkg::*;
(
  // System clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // SPI link
  input  wire logic spi_sclk_in,
  input  wire logic spi_cs_n_in,
  input  wire logic spi_mosi_in,
  output logic      spi_miso_out,
  output logic      spi_miso_oe_out,
  // Receiver and oscillator
  input  wire logic rx_data_in,
  input  wire logic rx_window_in,
  input  wire logic osc_stable_in,
  // Antenna drivers
  output logic      antenna_drive_a_out,
  output logic      antenna_drive_a_oe_out,
  output logic      antenna_drive_b_out,
  output logic      antenna_drive_b_oe_out,
  // Interrupt
  output logic      irq_out
);
  typedef struct packed {
    logic [2:0] bits;
    logic       seen;
    logic [7:0] sin;
    logic [7:0] sout;
  } nff_spi_type;

  typedef struct packed {
    logic t1, t2, t3, x1, x2, xp, w1, w2, m1, m2, o1, o2, o3;
    nff_cmd_type      cmd;
    logic [5:0]       addr;
    logic [7:0]       hold, ctrl, proto, txlvl;
    logic [6:0]       stat;
    nff_rx_state_type rxst;
    logic [6:0]       rcnt;
    logic [1:0]       rhalf;
    logic             rsel, h0;
    logic [3:0]       ridx;
    logic [8:0]       rsh;
    logic [7:0]       rcrc;
    nff_tx_state_type txst;
    logic [6:0]       tcnt;
    logic [1:0]       thalf;
    logic             tsel;
    logic [3:0]       tidx;
    logic [7:0]       tbyte, tcrc;
    logic             tcrcd, mod, ant, aoe;
  } nff_core_type;

  nff_spi_type  sp_r, sp_nxt;
  nff_evt_type  ev_r, ev_nxt;
  nff_core_type c_r, c_nxt;
  logic         spi_rst_n;
  logic         ev, rx_act, rx_push, rx_par_bad, tx_go, spi_push, spi_pop, flush;
  logic         transp, par_en, crc_en, rx_samp, rx_wrap, tx_wrap, tbit;
  logic [6:0]   hl;
  logic [7:0]   rx_byte;
  logic [8:0]   nsh;
  logic         f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]   f_in_data, f_out_data, f_count;
  logic         b_in_valid, b_in_ready, b_out_valid, b_out_ready;
  logic [7:0]   b_out_data;

  // Register read mux, shared by first and following read bytes
  function automatic logic [7:0] reg_rd(input nff_core_type s, input logic [5:0] a,
                                        input logic [7:0] cnt);
    case (a)
      ADDR_CTRL:  reg_rd = s.ctrl;
      ADDR_STAT:  reg_rd = {1'b0, s.stat};
      ADDR_CNT:   reg_rd = cnt;
      ADDR_PROTO: reg_rd = s.proto;
      ADDR_TXLVL: reg_rd = s.txlvl;
      default:    reg_rd = 8'h00;
    endcase
  endfunction

  function automatic logic [6:0] half_len(input logic [7:0] p);
    return {1'b0, p[PROTO_RATE_MSB:PROTO_RATE_LSB], 2'b00} + HALF_STEP;
  endfunction

  // Link side: chip select clears the byte counter between frames
  assign spi_rst_n = reset_n_in & ~spi_cs_n_in;

  // [R13] SPI byte shifter
  // Reply byte is loaded from hold, which is static by then
  always_comb begin
    sp_nxt      = sp_r;
    ev_nxt      = ev_r;
    sp_nxt.sin  = {sp_r.sin[6:0], spi_mosi_in};
    sp_nxt.sout = {sp_r.sout[6:0], 1'b0};
    sp_nxt.bits = sp_r.bits + 3'h1;
    if (sp_r.bits == BYTE_LAST) begin
      ev_nxt.data = {sp_r.sin[6:0], spi_mosi_in};
      ev_nxt.first = !sp_r.seen;
      ev_nxt.tog  = !ev_r.tog;
      sp_nxt.seen = 1'b1;
      sp_nxt.sout = c_r.hold;
    end
  end

  always_ff @(posedge spi_sclk_in or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      sp_r <= '0;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Toggle survives chip select so no false event is seen
  always_ff @(posedge spi_sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  assign transp = c_r.ctrl[CTRL_TRANSP];
  assign par_en = c_r.proto[PROTO_PAR];
  assign crc_en = c_r.proto[PROTO_CRC];
  // [R06] Bit timing from rate field
  assign hl      = half_len(c_r.proto);
  assign rx_samp = c_r.rcnt == (hl >> 1);
  assign rx_wrap = c_r.rcnt == hl - 7'h01;
  assign tx_wrap = c_r.tcnt == hl - 7'h01;
  // [R14] Receive window gate
  assign rx_act  = c_r.ctrl[CTRL_RXEN] && c_r.w2 && !transp;
  assign tbit    = (c_r.tidx == BIT_LAST_PAR) ? ~^c_r.tbyte : c_r.tbyte[c_r.tidx[2:0]];
  assign ev      = c_r.t2 ^ c_r.t3;

  // System side: crossings, register access, framers
  always_comb begin
    c_nxt = c_r;
    {rx_push, rx_par_bad, tx_go, spi_push, spi_pop, flush, b_out_ready} = '0;
    rx_byte = 8'h00;
    nsh     = {c_r.h0, c_r.rsh[8:1]};
    // Two flops before any use of an outside level
    {c_nxt.t1, c_nxt.t2, c_nxt.t3} = {ev_r.tog, c_r.t1, c_r.t2};
    {c_nxt.x1, c_nxt.x2, c_nxt.xp} = {rx_data_in, c_r.x1, c_r.x2};
    {c_nxt.w1, c_nxt.w2} = {rx_window_in, c_r.w1};
    {c_nxt.m1, c_nxt.m2} = {spi_mosi_in, c_r.m1};
    {c_nxt.o1, c_nxt.o2, c_nxt.o3} = {osc_stable_in, c_r.o1, c_r.o2};
    c_nxt.ctrl = c_r.ctrl & ~CTRL_PULSE_MASK;
    // Byte events; clears land before sets so sets win
    if (ev && ev_r.first) begin
      c_nxt.cmd  = nff_cmd_type'(ev_r.data[7:6]);
      c_nxt.addr = ev_r.data[5:0];
      if (ev_r.data[7:6] == CMD_RD) begin
        c_nxt.hold = reg_rd(c_r, ev_r.data[5:0], f_count);
      end
      if (ev_r.data[7:6] == CMD_FREAD) begin
        c_nxt.hold = f_out_data;
        spi_pop    = f_out_valid;
      end
    end else if (ev) begin
      unique case (c_r.cmd)
        CMD_WR: begin
          c_nxt.addr = c_r.addr + 6'h01;
          case (c_r.addr)
            ADDR_CTRL: begin
              c_nxt.ctrl = ev_r.data & ~CTRL_PULSE_MASK;
              tx_go      = ev_r.data[CTRL_GO] && c_r.txst == TX_IDLE && !transp;
              flush      = ev_r.data[CTRL_FLUSH];
            end
            ADDR_PROTO: c_nxt.proto = ev_r.data;
            ADDR_TXLVL: c_nxt.txlvl = ev_r.data;
            ADDR_STAT:  c_nxt.stat  = c_r.stat & ~ev_r.data[6:0];
            default: ;
          endcase
        end
        CMD_RD: begin
          c_nxt.addr = c_r.addr + 6'h01;
          c_nxt.hold = reg_rd(c_r, c_r.addr + 6'h01, f_count);
        end
        // [R10] Loads refused while receiving
        CMD_FLOAD: spi_push = !rx_act;
        CMD_FREAD: begin
          c_nxt.hold = f_out_data;
          spi_pop    = f_out_valid;
        end
      endcase
    end

    // [R12] Oscillator stable event
    if (c_r.o2 && !c_r.o3) begin
      c_nxt.stat[STAT_OSC] = 1'b1;
    end

    // [R01] Receive: SOF is four high halves, Manchester data
    c_nxt.rcnt = rx_wrap ? '0 : c_r.rcnt + 7'h01;
    if (!rx_act) begin
      c_nxt.rxst = RX_IDLE;
    end else begin
      unique case (c_r.rxst)
        RX_IDLE: begin
          c_nxt.rcnt = '0;
          if (c_r.x2 && !c_r.xp) begin
            c_nxt.rxst  = RX_SOF;
            c_nxt.rhalf = '0;
          end
        end
        RX_SOF: begin
          if (rx_samp && !c_r.x2) begin
            c_nxt.rxst = RX_IDLE;
          end else if (rx_wrap) begin
            c_nxt.rhalf = c_r.rhalf + 2'h1;
            if (c_r.rhalf == SOF_LAST) begin
              c_nxt.rxst = RX_DATA;
              c_nxt.rsel = 1'b0;
              c_nxt.ridx = '0;
              c_nxt.rcrc = CRC_INIT;
            end
          end
        end
        RX_DATA: begin
          if (rx_wrap) begin
            c_nxt.rsel = !c_r.rsel;
          end
          if (rx_samp && !c_r.rsel) begin
            c_nxt.h0 = c_r.x2;
          end
          if (rx_samp && c_r.rsel) begin
            unique case ({c_r.h0, c_r.x2})
              2'b10, 2'b01: begin
                // [R03] Byte assembly into FIFO
                c_nxt.rsh  = nsh;
                c_nxt.ridx = c_r.ridx + 4'h1;
                if (c_r.ridx == (par_en ? BIT_LAST_PAR : BIT_LAST)) begin
                  c_nxt.ridx = '0;
                  rx_byte    = par_en ? nsh[7:0] : nsh[8:1];
                  rx_push    = 1'b1;
                  c_nxt.rcrc = nff_crc8(c_r.rcrc, rx_byte);
                  // [R02] Odd parity check
                  rx_par_bad = par_en && !(^nsh);
                end
              end
              2'b00: begin
                // [R02] CRC residue must be zero at EOF
                c_nxt.rxst = RX_IDLE;
                c_nxt.stat[STAT_RXOK] = 1'b1;
                if (crc_en && c_r.rcrc != CRC_INIT) begin
                  c_nxt.stat[STAT_CRC] = 1'b1;
                end
              end
              2'b11: begin
                c_nxt.rxst = RX_IDLE;
                c_nxt.stat[STAT_CODE] = 1'b1;
              end
            endcase
          end
        end
      endcase
    end
    // [R15] Error flag feeds the interrupt
    if (rx_par_bad) begin
      c_nxt.stat[STAT_PAR] = 1'b1;
    end
    if (rx_push && !f_in_ready) begin
      c_nxt.stat[STAT_OVF] = 1'b1;
    end

    // [R04] Transmit: bytes from the buffer, CRC appended last
    c_nxt.tcnt = tx_wrap ? '0 : c_r.tcnt + 7'h01;
    unique case (c_r.txst)
      TX_IDLE: begin
        c_nxt.tcnt = '0;
        c_nxt.mod  = 1'b0;
        if (tx_go) begin
          c_nxt.txst  = TX_SOF;
          c_nxt.thalf = '0;
          c_nxt.tcrc  = CRC_INIT;
          c_nxt.tcrcd = 1'b0;
        end
      end
      // [R05] SOF symbol
      TX_SOF: begin
        c_nxt.mod = 1'b1;
        if (tx_wrap) begin
          c_nxt.thalf = c_r.thalf + 2'h1;
          if (c_r.thalf == SOF_LAST) begin
            c_nxt.txst = TX_LOAD;
          end
        end
      end
      // Empty FIFO ends the frame, so load it before go
      TX_LOAD: begin
        c_nxt.tcnt = '0;
        c_nxt.tidx = '0;
        c_nxt.tsel = 1'b0;
        if (b_out_valid) begin
          b_out_ready = 1'b1;
          c_nxt.tbyte = b_out_data;
          c_nxt.tcrc  = nff_crc8(c_r.tcrc, b_out_data);
          c_nxt.txst  = TX_BIT;
        end else if (!f_out_valid) begin
          if (crc_en && !c_r.tcrcd) begin
            c_nxt.tbyte = c_r.tcrc;
            c_nxt.tcrcd = 1'b1;
            c_nxt.txst  = TX_BIT;
          end else begin
            c_nxt.txst  = TX_EOF;
            c_nxt.thalf = '0;
          end
        end
      end
      // [R05] Manchester halves, parity after the eighth bit
      TX_BIT: begin
        c_nxt.mod = c_r.tsel ? ~tbit : tbit;
        if (tx_wrap) begin
          c_nxt.tsel = !c_r.tsel;
          if (c_r.tsel) begin
            c_nxt.tidx = c_r.tidx + 4'h1;
            if (c_r.tidx == (par_en ? BIT_LAST_PAR : BIT_LAST)) begin
              c_nxt.txst = TX_LOAD;
            end
          end
        end
      end
      // [R05] EOF symbol
      TX_EOF: begin
        c_nxt.mod = 1'b0;
        if (tx_wrap) begin
          c_nxt.thalf = c_r.thalf + 2'h1;
          if (c_r.thalf == SOF_LAST) begin
            c_nxt.txst = TX_IDLE;
            c_nxt.stat[STAT_TXOK] = 1'b1;
          end
        end
      end
    endcase

    // [R08] Transparent mode takes the modulation from MOSI
    c_nxt.ant = transp ? c_r.m2 : c_r.mod;
    // [R11] Driver tristate code
    c_nxt.aoe = c_r.txlvl != TX_HIZ_CODE;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      c_r       <= '0;
      c_r.ctrl  <= CTRL_RESET;
      c_r.proto <= PROTO_RESET;
      c_r.txlvl <= TXLVL_RESET;
      c_r.aoe   <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // [R10] FIFO source and sink follow the mode
  assign f_in_valid  = spi_push || rx_push;
  assign f_in_data   = spi_push ? ev_r.data : rx_byte;
  assign f_out_ready = spi_pop || (c_r.txst != TX_IDLE && b_in_ready);
  assign b_in_valid  = f_out_valid && c_r.txst != TX_IDLE && !spi_pop;

  // [R09] Main store depth
  nff_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (flush),
    .in_valid_in   (f_in_valid),
    .in_data_in    (f_in_data),
    .in_ready_out  (f_in_ready),
    .out_valid_out (f_out_valid),
    .out_data_out  (f_out_data),
    .out_ready_in  (f_out_ready),
    .count_out     (f_count)
  );

  // Staging buffer drains the main FIFO while bits go out, stalling it when full
  nff_fifo #(.W(8), .D(BUF_DEPTH)) u_buf (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (flush),
    .in_valid_in   (b_in_valid),
    .in_data_in    (f_out_data),
    .in_ready_out  (b_in_ready),
    .out_valid_out (b_out_valid),
    .out_data_out  (b_out_data),
    .out_ready_in  (b_out_ready),
    .count_out     ()
  );

  // [R07] Transparent MISO carries the receiver output
  assign spi_miso_out           = transp ? c_r.x2 : sp_r.sout[7];
  assign spi_miso_oe_out        = !spi_cs_n_in || transp;
  assign antenna_drive_a_out    = c_r.ant;
  assign antenna_drive_b_out    = c_r.ant;
  assign antenna_drive_a_oe_out = c_r.aoe;
  assign antenna_drive_b_oe_out = c_r.aoe;
  // [R12] Any sticky status raises the interrupt
  assign irq_out = |c_r.stat;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_hiz_drivers: assert property (c_r.txlvl == TX_HIZ_CODE |=> // [R11]
    !antenna_drive_a_oe_out && !antenna_drive_b_oe_out) else $error("drivers not tristated");
  a_transp_miso: assert property (transp |-> spi_miso_out == c_r.x2) // [R07]
    else $error("miso not bypassed");
  a_transp_mod: assert property (transp |=> antenna_drive_a_out == $past(c_r.m2)) // [R08]
    else $error("mosi not driving modulation");
  a_osc_irq: assert property (c_r.o2 && !c_r.o3 |=> c_r.stat[STAT_OSC] && irq_out) // [R12]
    else $error("oscillator interrupt missing");
  a_parity_flag: assert property (rx_par_bad |=> c_r.stat[STAT_PAR] && irq_out) // [R15]
    else $error("parity error not flagged");
  a_rx_window: assert property (!c_r.w2 |=> c_r.rxst == RX_IDLE) // [R14]
    else $error("receive outside window");
  a_rx_store: assert property (rx_push && f_in_ready && !f_out_ready |=> // [R03]
    f_count == $past(f_count) + 8'h01) else $error("received byte not stored");
  a_tx_sof: assert property (c_r.txst == TX_SOF ##1 c_r.txst == TX_SOF |-> c_r.mod) // [R05]
    else $error("sof level wrong");
  a_tx_eof: assert property (c_r.txst == TX_EOF |=> !c_r.mod) // [R05]
    else $error("eof level wrong");
  a_tx_start: assert property (tx_go |=> c_r.txst == TX_SOF ##[1:300] c_r.txst == TX_LOAD) // [R04]
    else $error("frame start too slow");

  c_tx_frame: cover property (c_r.txst == TX_EOF ##1 c_r.txst == TX_IDLE);
  c_rx_frame: cover property (c_r.rxst == RX_DATA ##1 c_r.rxst == RX_IDLE);
  c_fifo_full: cover property (!f_in_ready);
  c_transp: cover property (transp && c_r.m2);
endmodule

// ===== design/nff_mem.sv
// Small RAM with registered read data
// Assumes a single clock; write data bypasses to a same-address read
`timescale 1ns/1ps
module nff_mem #(
  parameter int W  = 8,
  parameter int D  = 8,
  parameter int AW = 3
) (
  // Clock
  input  wire logic          clk_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] wa_in,
  input  wire logic [W-1:0]  wd_in,
  // Read port
  input  wire logic [AW-1:0] ra_in,
  output logic [W-1:0]       rd_out
);
  logic [W-1:0] mem [D];

  // Storage has no reset to stay a plain RAM
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[wa_in] <= wd_in;
    end
    rd_out <= (we_in && wa_in == ra_in) ? wd_in : mem[ra_in];
  end
endmodule

// ===== design/nff_pkg.sv
// Constants, types and helpers for the reader framing path
// Assumes one system clock and an SPI link clock from the controller
//
// Contract
// [R01] Receive finds SOF, EOF and data bits
// [R02] Receive checks parity and CRC per frame
// [R03] Received bits become bytes pushed into FIFO
// [R04] Transmit takes FIFO bytes, adds parity, CRC
// [R05] Transmit adds SOF, EOF and encodes modulation
// [R06] Format follows configured protocol and bit rate
// [R07] Transparent mode routes receiver output to MISO
// [R08] Transparent mode: MOSI level drives the modulation
// [R09] FIFO holds 96 bytes
// [R10] FIFO holds receive or transmit data by mode
// [R11] FFh in tx_driver_level tristates both drivers
// [R12] Interrupt once oscillator is stable
// [R13] Four-wire SPI with controller as master
// [R14] Receive processing only while window is high
// [R15] Parity or CRC error sets flag, interrupt
package nff_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_CTRL  = 6'h01;
  localparam logic [5:0] ADDR_STAT  = 6'h02;
  localparam logic [5:0] ADDR_CNT   = 6'h03;
  localparam logic [5:0] ADDR_PROTO = 6'h04;
  localparam logic [5:0] ADDR_TXLVL = 6'h27;
  // Control bits; go and flush are pulses, never stored
  localparam int CTRL_GO     = 0;
  localparam int CTRL_TRANSP = 1;
  localparam int CTRL_RXEN   = 2;
  localparam int CTRL_FLUSH  = 3;
  localparam logic [7:0] CTRL_PULSE_MASK = 8'h09;
  // Protocol bits and half-bit rate field
  localparam int PROTO_PAR      = 0;
  localparam int PROTO_CRC      = 1;
  localparam int PROTO_RATE_LSB = 4;
  localparam int PROTO_RATE_MSB = 7;
  // Sticky status bits, write one to clear
  localparam int STAT_OSC  = 0;
  localparam int STAT_PAR  = 1;
  localparam int STAT_CRC  = 2;
  localparam int STAT_RXOK = 3;
  localparam int STAT_TXOK = 4;
  localparam int STAT_CODE = 5;
  localparam int STAT_OVF  = 6;
  // Reset values and codes
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] PROTO_RESET = 8'h03;
  localparam logic [7:0] TXLVL_RESET = 8'h00;
  localparam logic [7:0] TX_HIZ_CODE = 8'hFF;
  // Framing constants
  localparam logic [1:0] SOF_LAST     = 2'h3;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_LAST_PAR = 4'h8;
  localparam logic [2:0] BYTE_LAST    = 3'h7;
  localparam logic [7:0] CRC_POLY     = 8'h07;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  localparam logic [6:0] HALF_STEP    = 7'h04;
  localparam int FIFO_DEPTH = 96;
  localparam int BUF_DEPTH  = 8;

  typedef enum logic [1:0] {
    CMD_WR    = 2'h0,
    CMD_RD    = 2'h1,
    CMD_FLOAD = 2'h2,
    CMD_FREAD = 2'h3
  } nff_cmd_type;

  typedef enum logic [1:0] {RX_IDLE, RX_SOF, RX_DATA} nff_rx_state_type;
  typedef enum logic [2:0] {TX_IDLE, TX_SOF, TX_LOAD, TX_BIT, TX_EOF} nff_tx_state_type;

  // Byte event handed from the link clock to the system clock
  typedef struct packed {
    logic       tog;
    logic       first;
    logic [7:0] data;
  } nff_evt_type;

  // CRC-8 step over one byte, MSB first
  function automatic logic [7:0] nff_crc8(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] r;
    r = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// ===== sim/nff_spi_master.sv
// Controller model: SPI master for the framing path
// Assumes mode 0, MSB first, 30 ns sclk, sclk still between frames
`timescale 1ns/1ps
module nff_spi_master (
  // Link pins
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // Idle link, device not selected
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic start();
    cs_n_out = 1'b0;
    #30;
  endtask
  task automatic stop();
    #30 cs_n_out = 1'b1;
    #60;
  endtask
  // byte exchange, sampled before the slave shifts
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      #15 sclk_out = 1'b1;
      rx[i] = miso_in;
      #15 sclk_out = 1'b0;
    end
    mosi_out = ~tx[0]; // Released line must not look stable
  endtask
  task automatic level(input logic b);
    mosi_out = b;
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the framing path
// Assumes the SPI model drives the link pins
`timescale 1ns/1ps
module tb_top;
  logic clk_in, reset_n_in, rx_data_in, rx_window_in, osc_stable_in;
  logic sclk, cs_n, mosi, miso, miso_oe, irq_out;
  logic drv_a, drv_a_oe, drv_b, drv_b_oe;
  logic [7:0] rq [$];
  int errors, compares;
  nff_spi_master m_spi (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  nff_frame_fifo_path i_nff_frame_fifo_path (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
    .rx_data_in(rx_data_in), .rx_window_in(rx_window_in), .osc_stable_in(osc_stable_in),
    .antenna_drive_a_out(drv_a), .antenna_drive_a_oe_out(drv_a_oe),
    .antenna_drive_b_out(drv_b), .antenna_drive_b_oe_out(drv_b_oe), .irq_out(irq_out));
  // System clock, 50 ns
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One whole frame, replies kept per byte
  task automatic frame(input logic [7:0] tx [$]);
    logic [7:0] r;
    rq = {};
    m_spi.start();
    foreach (tx[i]) begin
      m_spi.xfer(tx[i], r);
      rq.push_back(r);
    end
    m_spi.stop();
    repeat (6) @(posedge clk_in);
  endtask
  // Bounded wait on a design output
  task automatic wait_for(input logic v, input bit on_a);
    int n;
    n = 0;
    while ((on_a ? drv_a : irq_out) !== v && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 4000) begin
      errors++;
      final_report();
    end
  endtask
  // One air half-bit at rate 0
  task automatic half(input logic b);
    rx_data_in <= b;
    repeat (4) @(posedge clk_in);
  endtask
  // One air frame: SOF, one byte LSB first, EOF
  task automatic air_frame(input logic [7:0] d);
    repeat (4) half(1'b1);
    for (int i = 0; i < 8; i++) begin
      half(d[i]);
      half(!d[i]);
    end
    repeat (4) half(1'b0);
    repeat (8) @(posedge clk_in);
  endtask
  initial begin
    reset_n_in = 1'b0;
    rx_data_in = 1'b0;
    rx_window_in = 1'b0;
    osc_stable_in = 1'b0;
    errors = 0;
    compares = 0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    frame('{8'h41, 0, 0, 0, 0, 0, 0});
    chk("ctrl", 8'h00, rq[2]);
    chk("stat", 8'h00, rq[3]);
    chk("cnt", 8'h00, rq[4]);
    chk("proto", 8'h03, rq[5]);
    chk("unmapped", 8'h00, rq[6]);
    $display("test reset done");
    frame('{8'h27, 8'hFF});
    chk("oe_a", 8'h00, {7'h00, drv_a_oe}); // drivers off
    chk("oe_b", 8'h00, {7'h00, drv_b_oe}); // drivers off
    frame('{8'h27, 8'h00});
    chk("oe_a", 8'h01, {7'h00, drv_a_oe}); // drivers back
    $display("test tristate done");
    osc_stable_in <= 1'b1;
    wait_for(1'b1, 1'b0); // oscillator ready
    frame('{8'h42, 0, 0});
    chk("stat", 8'h01, rq[2]); // status bit
    frame('{8'h02, 8'hFF, 8'h00, 8'h00});
    chk("irq", 8'h00, {7'h00, irq_out});
    $display("test osc done");
    frame('{8'h80, 8'h11, 8'h22, 8'h33});
    frame('{8'h43, 0, 0});
    chk("cnt", 8'h03, rq[2]); // loaded bytes
    frame('{8'h01, 8'h01});
    wait_for(1'b1, 1'b1);
    repeat (8) @(posedge clk_in);
    chk("sof", 8'h01, {7'h00, drv_a}); // start symbol
    wait_for(1'b1, 1'b0);
    frame('{8'h42, 0, 0, 0});
    chk("stat", 8'h10, rq[2]); // frame sent
    chk("cnt", 8'h00, rq[3]); // FIFO drained
    frame('{8'h02, 8'hFF});
    $display("test transmit done");
    frame('{8'h01, 8'h04});
    rx_window_in <= 1'b1;
    air_frame(8'hA5);
    frame('{8'h42, 0, 0, 0});
    chk("stat", 8'h08, rq[2]); // clean frame
    chk("cnt", 8'h01, rq[3]); // byte stored
    frame('{8'hC0, 0, 0});
    chk("fifo", 8'hA5, rq[2]); // byte value
    // CRC on, but the frame carries no CRC byte
    frame('{8'h02, 8'hFF, 8'h00, 8'h02});
    air_frame(8'hA5);
    frame('{8'h42, 0, 0});
    chk("stat", 8'h0C, rq[2]); // CRC error flagged
    chk("irq", 8'h01, {7'h00, irq_out}); // error interrupt
    $display("test receive done");
    frame('{8'h01, 8'h02});
    rx_data_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("miso", 8'h01, {7'h00, miso}); // receiver on MISO
    chk("miso_oe", 8'h01, {7'h00, miso_oe}); // pin driven
    m_spi.level(1'b1);
    repeat (5) @(posedge clk_in);
    chk("drv_a", 8'h01, {7'h00, drv_a}); // MOSI modulates
    m_spi.level(1'b0);
    repeat (5) @(posedge clk_in);
    chk("drv_b", 8'h00, {7'h00, drv_b}); // MOSI modulates
    $display("test transparent done");
    final_report();
  end
endmodule
